//--- hw/sbp_gpio_pkg.sv
package sbp_gpio_pkg;
    // -----------------------------------------------------------------
    // Register indices, byte address is four times the index
    // -----------------------------------------------------------------
    localparam logic [7:0] IDX_DATA = 8'h05;    // Pin data / output latch
    localparam logic [7:0] IDX_INTCTL = 8'h0B;  // Interrupt control
    localparam logic [7:0] IDX_OPTION = 8'h81;  // Option, global pull-up
    localparam logic [7:0] IDX_DIR = 8'h85;     // Direction bits
    localparam logic [7:0] IDX_PULLUP = 8'h95;  // Pull-up enable bits
    localparam logic [7:0] IDX_CHGEN = 8'h96;   // Change enable bits
    localparam logic [7:0] IDX_ANALOG = 8'h9F;  // Analog select
    // -----------------------------------------------------------------
    // Field positions and masks
    // -----------------------------------------------------------------
    localparam int PIN_W = 6;                   // Implemented pins
    localparam int IN_ONLY_PIN = 3;             // Input only pin
    localparam int BIT_GLB_IRQ = 7;             // Global irq enable
    localparam int BIT_PORT_IRQ = 3;            // Port change irq enable
    localparam int BIT_PORT_FLAG = 0;           // Port change flag
    localparam int BIT_PULL_DIS = 7;            // Global pull-up disable
    localparam logic [5:0] PULLUP_MASK = 6'h37; // Pins with a pull-up
    localparam logic [5:0] IN_ONLY_MASK = 6'h08;// Input only pin mask
    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [5:0] RST_DIR = 6'h3F;
    localparam logic [5:0] RST_PULLUP = 6'h37;
    localparam logic [5:0] RST_CHGEN = 6'h00;
    localparam logic [5:0] RST_LATCH = 6'h00;
    localparam logic [7:0] RST_OPTION = 8'hFF;
    localparam logic [3:0] RST_ANALOG = 4'hF;
    localparam logic [5:0] RST_SYNC = 6'h00;
endpackage

//--- hw/sbp_gpio_port.sv
// Overview of operation
// - Six pins, bits 7-6 read zero
// - Direction one tri-states the driver
// - Direction zero drives the output latch
// - Pin 3 input only, direction reads one
// - Reads return pins, writes set latch
// - Writes store modified value into latch
// - Pin 3 reads zero under master clear
// - Analog pins read zero
// - Direction still drives analog pins
// - Enabled peripheral takes over its pin, except pin 3
// - Pull-ups on pins 5,4,2,1,0 only
// - Output pins lose their pull-up
// - Global control gates all pull-ups
// - Six change enables, reset cleared
// - Mismatch against last data access sets flag
// - Persisting mismatch keeps setting flag
// - Data access relatches, software clears flag
// - Port change can wake from sleep
// - Change during read may be lost
// - Core interrupt needs global enable
// - Global pull-up disable, zero enables
// - Flag sticky until software clears
// - Separate enable gates change interrupt
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module sbp_gpio_port #(
    parameter int ADR_W = 10
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [ADR_W-1:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    input wire logic [sbp_gpio_pkg::PIN_W-1:0] padIn,
    output logic [sbp_gpio_pkg::PIN_W-1:0] padOut,
    output logic [sbp_gpio_pkg::PIN_W-1:0] padOe_n,
    output logic [sbp_gpio_pkg::PIN_W-1:0] pullUpOn,
    input wire logic [sbp_gpio_pkg::PIN_W-1:0] periphOwn,
    input wire logic [sbp_gpio_pkg::PIN_W-1:0] periphOut,
    input wire logic [sbp_gpio_pkg::PIN_W-1:0] periphOe_n,
    input wire logic masterClearPinEnable,
    output logic irqRequest,
    output logic wakeRequest
);
    import sbp_gpio_pkg::*;

    // -----------------------------------------------------------------
    // Register state
    // -----------------------------------------------------------------
    // Bus side
    logic ack_q;                       // Bus acknowledge
    logic [31:0] rdat_q;               // Captured read data

    // Software visible configuration
    logic [5:0] latch_q;               // Output data latch
    logic [5:0] dir_q;                 // Direction bits
    logic [5:0] pullUpEn_q;            // Pull-up enable bits
    logic [5:0] changeEn_q;            // Change enable bits
    logic [7:0] option_q;              // Option register
    logic [3:0] analogSel_q;           // Analog select bits
    logic globalIrqEn_q;               // Global irq enable
    logic portIrqEn_q;                 // Port change irq enable

    // Pin sampling and change detection
    logic flag_q;                      // Port change flag
    logic [5:0] syncA_q;               // Synchroniser stage one
    logic [5:0] syncB_q;               // Synchroniser stage two
    logic [5:0] ref_q;                 // Value latched at last data access

    // Decoded and combinational values
    logic [5:0] analog;                // Pins in analog mode
    logic [5:0] mismatch;              // Enabled pins that differ
    logic [5:0] pinRead;               // Masked port read value
    logic [7:0] idx;                   // Register index
    logic access;                      // Access completes this edge
    logic wrLo;                        // Write using the low byte lane

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    // Zero-extend a six-bit field to a bus word
    function automatic logic [31:0] ext6(input logic [5:0] v);
        ext6 = {26'h0000000, v};
    endfunction

    // Index hit for a completing access
    function automatic logic hit(input logic [7:0] i);
        hit = access && (idx == i);
    endfunction

    // -----------------------------------------------------------------
    // Bus decode
    // -----------------------------------------------------------------
    // Word index from the byte address
    assign idx = wbAdr[9:2];

    // Access completes at the edge where ack is high
    assign access = wbCyc && wbStb && ack_q;

    // Only the low byte lane carries register bits
    assign wrLo = wbWe && wbSel[0];

    // Analog select bits map onto pins 0,1,2 and 4
    assign analog = {1'b0, analogSel_q[3], 1'b0, analogSel_q[2:0]};

    // Port read: pins, analog and master clear masked
    always_comb begin
        pinRead = syncB_q & ~analog;
        // Master clear owns the input only pin
        if (masterClearPinEnable) begin
            pinRead[IN_ONLY_PIN] = 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Wishbone slave
    // -----------------------------------------------------------------
    // Ack one cycle after the request, dropped the next cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wbCyc && wbStb && !ack_q;
        end
    end

    // Read data captured as ack rises, unmapped reads zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdat_q <= 32'h00000000;
        end else if (wbCyc && wbStb && !ack_q) begin
            case (idx)
                IDX_DATA: rdat_q <= ext6(pinRead);
                IDX_DIR: rdat_q <= ext6(dir_q | IN_ONLY_MASK);
                IDX_PULLUP: rdat_q <= ext6(pullUpEn_q & PULLUP_MASK);
                IDX_CHGEN: rdat_q <= ext6(changeEn_q);
                IDX_OPTION: rdat_q <= {24'h000000, option_q};
                IDX_ANALOG: rdat_q <= {28'h0000000, analogSel_q};
                IDX_INTCTL: begin
                    rdat_q <= 32'h00000000;
                    rdat_q[BIT_GLB_IRQ] <= globalIrqEn_q;
                    rdat_q[BIT_PORT_IRQ] <= portIrqEn_q;
                    rdat_q[BIT_PORT_FLAG] <= flag_q;
                end
                default: rdat_q <= 32'h00000000;
            endcase
        end
    end

    assign wbAck = ack_q;
    assign wbDatR = rdat_q;

    // -----------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------
    // Output latch takes the modified value the core writes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            latch_q <= RST_LATCH;
        end else if (hit(IDX_DATA) && wrLo) begin
            latch_q <= wbDatW[5:0];
        end
    end

    // Direction bits, pin 3 held as input
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dir_q <= RST_DIR;
        end else if (hit(IDX_DIR) && wrLo) begin
            dir_q <= wbDatW[5:0] | IN_ONLY_MASK;
        end
    end

    // Pull-up enables, pin 3 not implemented
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pullUpEn_q <= RST_PULLUP;
        end else if (hit(IDX_PULLUP) && wrLo) begin
            pullUpEn_q <= wbDatW[5:0] & PULLUP_MASK;
        end
    end

    // Change enables, cleared at reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            changeEn_q <= RST_CHGEN;
        end else if (hit(IDX_CHGEN) && wrLo) begin
            changeEn_q <= wbDatW[5:0];
        end
    end

    // Option register, global pull-up disable sets at reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            option_q <= RST_OPTION;
        end else if (hit(IDX_OPTION) && wrLo) begin
            option_q <= wbDatW[7:0];
        end
    end

    // Analog select bits
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            analogSel_q <= RST_ANALOG;
        end else if (hit(IDX_ANALOG) && wrLo) begin
            analogSel_q <= wbDatW[3:0];
        end
    end

    // Interrupt enables
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            globalIrqEn_q <= 1'b0;
            portIrqEn_q <= 1'b0;
        end else if (hit(IDX_INTCTL) && wrLo) begin
            globalIrqEn_q <= wbDatW[BIT_GLB_IRQ];
            portIrqEn_q <= wbDatW[BIT_PORT_IRQ];
        end
    end

    // -----------------------------------------------------------------
    // Pin drivers and pull-ups
    // -----------------------------------------------------------------
    // Peripheral owns pin when enabled, else latch and direction; pin 3 always tri-stated
    always_comb begin
        for (int i = 0; i < PIN_W; i++) begin
            if (periphOwn[i]) begin
                padOut[i] = periphOut[i];
                padOe_n[i] = periphOe_n[i];
            end else begin
                padOut[i] = latch_q[i];
                padOe_n[i] = dir_q[i];
            end
        end
        padOut[IN_ONLY_PIN] = 1'b0;
        padOe_n[IN_ONLY_PIN] = 1'b1;
    end

    // Pull-up only for inputs and with global enable
    assign pullUpOn = pullUpEn_q & PULLUP_MASK & dir_q
        & {PIN_W{!option_q[BIT_PULL_DIS]}};

    // -----------------------------------------------------------------
    // Pin synchroniser and change detection
    // -----------------------------------------------------------------
    // Two flip-flop synchroniser on the pads
    // Only stage two feeds reads and compares
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            syncA_q <= RST_SYNC;
            syncB_q <= RST_SYNC;
        end else begin
            syncA_q <= padIn;
            syncB_q <= syncA_q;
        end
    end

    // Reference relatched on any data access
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ref_q <= RST_SYNC;
        end else if (hit(IDX_DATA)) begin
            ref_q <= syncB_q;
        end
    end

    assign mismatch = (syncB_q ^ ref_q) & changeEn_q;

    // Sticky flag, a standing mismatch wins over the clear
    // Clear takes effect only when no enabled pin differs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flag_q <= 1'b0;
        end else if (|mismatch) begin
            flag_q <= 1'b1;
        end else if (hit(IDX_INTCTL) && wrLo && !wbDatW[BIT_PORT_FLAG]) begin
            flag_q <= 1'b0;
        end
    end

    // Interrupt and wake requests
    // Wake needs only the port enable, the core also the global one
    assign wakeRequest = flag_q && portIrqEn_q;
    assign irqRequest = flag_q && portIrqEn_q && globalIrqEn_q;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // -----------------------------------------------------------------
    // Pin drive and pull-up checks
    // -----------------------------------------------------------------
    in_only_pin_a: assert property (padOe_n[IN_ONLY_PIN] && !pullUpOn[IN_ONLY_PIN])
        else $error("input only pin driven or pulled");

    dir_bit3_a: assert property (dir_q[IN_ONLY_PIN])
        else $error("input only direction bit cleared");

    out_drive_a: assert property ((~periphOwn & ~dir_q & (padOut ^ latch_q)) == 6'h00)
        else $error("output pin not driven from latch");

    tri_state_a: assert property ((~periphOwn & dir_q & ~padOe_n) == 6'h00)
        else $error("input pin driven");

    pullup_out_a: assert property ((pullUpOn & ~dir_q) == 6'h00)
        else $error("pull-up on output pin");

    pullup_global_a: assert property (option_q[BIT_PULL_DIS] |-> pullUpOn == 6'h00)
        else $error("pull-up while globally disabled");

    // -----------------------------------------------------------------
    // Bus and register checks
    // -----------------------------------------------------------------
    // Ack pulses once per request
    ack_pulse_a: assert property (wbCyc && wbStb && !ack_q |=> ack_q ##1 !ack_q)
        else $error("ack not a single cycle pulse");

    analog_read_a: assert property (
        wbCyc && wbStb && !ack_q && idx == IDX_DATA |=> (wbDatR[5:0] & analog) == 6'h00)
        else $error("analog pin read nonzero");

    mclr_read_a: assert property (
        masterClearPinEnable && wbCyc && wbStb && !ack_q && idx == IDX_DATA
        |=> !wbDatR[IN_ONLY_PIN])
        else $error("input only pin read under master clear");

    upper_zero_a: assert property (
        wbAck && idx == IDX_DATA |-> wbDatR[31:6] == 26'h0000000)
        else $error("unimplemented port bits read nonzero");

    // Written value lands in the latch
    latch_write_a: assert property (hit(IDX_DATA) && wrLo |=> latch_q == $past(wbDatW[5:0]))
        else $error("latch not written");

    // Write without the low byte lane leaves the register alone
    sel_ignore_a: assert property (hit(IDX_DIR) && wbWe && !wbSel[0] |=> $stable(dir_q))
        else $error("direction written without byte lane");

    // -----------------------------------------------------------------
    // Change detection checks
    // -----------------------------------------------------------------
    pin_sync_a: assert property (
        $past(reset_n) && $past(reset_n, 2) |-> syncB_q == $past(padIn, 2))
        else $error("pin synchroniser depth wrong");

    relatch_ref_a: assert property (hit(IDX_DATA) |=> ref_q == $past(syncB_q))
        else $error("reference not relatched");

    flag_set_a: assert property (mismatch != 6'h00 |=> flag_q [*2])
        else $error("mismatch did not hold flag");

    // Flag stays until software clears it
    flag_hold_a: assert property (
        flag_q && !(hit(IDX_INTCTL) && wrLo && !wbDatW[BIT_PORT_FLAG]) |=> flag_q)
        else $error("flag dropped without a clear");

    flag_clear_a: assert property (
        hit(IDX_INTCTL) && wrLo && !wbDatW[BIT_PORT_FLAG] && mismatch == 6'h00 |=> !flag_q)
        else $error("flag clear ignored");

    irq_gate_a: assert property (irqRequest |-> globalIrqEn_q && portIrqEn_q && flag_q)
        else $error("interrupt without enables");

    wake_gate_a: assert property (flag_q && portIrqEn_q |-> wakeRequest)
        else $error("enabled port change did not wake");
endmodule
`default_nettype wire

//--- sim/sbp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// External pad model
// ---------------------------------------------------------------
module sbp_pin_model (
    input wire logic clk,
    input wire logic [5:0] padOut,
    input wire logic [5:0] padOe_n,
    input wire logic [5:0] pullUpOn,
    input wire logic [5:0] extVal,
    input wire logic [5:0] extEn,
    output logic [5:0] padIn
);
    logic [5:0] lastLevel_q; // Previous pad level
    // Own driver first, then outside driver, pull-up, else drifting
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!padOe_n[i]) begin
                padIn[i] = padOut[i];
            end else if (extEn[i]) begin
                padIn[i] = extVal[i];
            end else if (pullUpOn[i]) begin
                padIn[i] = 1'b1;
            end else begin
                padIn[i] = ~lastLevel_q[i]; // Floating pad never holds its value
            end
        end
    end
    // Remember the level for the floating case
    always_ff @(posedge clk) begin
        lastLevel_q <= padIn;
    end
endmodule
`default_nettype wire

//--- sim/sbp_gpio_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sbp_gpio_port_tb;
    import sbp_gpio_pkg::*;
    // ---------------------------------------------------------------
    // Stimulus and observation
    // ---------------------------------------------------------------
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, mclr = 1'b0;
    logic [9:0] wbAdr = 10'h000;
    logic [3:0] wbSel = 4'hF;
    logic [31:0] wbDatW = 32'h0, wbDatR;
    logic wbAck, irqRequest, wakeRequest;
    logic [5:0] padIn, padOut, padOe_n, pullUpOn;
    logic [5:0] own = 6'h00, pOut = 6'h00, pOe_n = 6'h3F;
    logic [5:0] extVal = 6'h2A, extEn = 6'h3F;
    int errTotal = 0;
    int nTests = 0;
    always #12.5 clk = ~clk;
    sbp_gpio_port #(.ADR_W(10)) DUT (.clk(clk), .reset_n(reset_n), .wbCyc(wbCyc),
        .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
        .wbDatR(wbDatR), .wbAck(wbAck), .padIn(padIn), .padOut(padOut),
        .padOe_n(padOe_n), .pullUpOn(pullUpOn), .periphOwn(own), .periphOut(pOut),
        .periphOe_n(pOe_n), .masterClearPinEnable(mclr), .irqRequest(irqRequest),
        .wakeRequest(wakeRequest));
    sbp_pin_model pins (.clk(clk), .padOut(padOut), .padOe_n(padOe_n),
        .pullUpOn(pullUpOn), .extVal(extVal), .extEn(extEn), .padIn(padIn));
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errTotal++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle, held until ack is sampled high
    task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                        input logic [3:0] sel, output logic [31:0] rdat);
        int n;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbSel <= sel;
        wbAdr <= {idx, 2'b00};
        wbDatW <= {24'h0, wd};
        n = 0;
        // Look at ack where it is settled, the next rising edge samples it
        do begin
            @(negedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        @(posedge clk);
        rdat = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        if (n >= 20) begin
            errTotal++;
            $display("[ERR] %0t no acknowledge", $time);
            finish_test();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] d;
        xfer(1'b1, idx, v, 4'hF, d);
    endtask
    // Write with chosen byte lanes
    task automatic wrs(input logic [7:0] idx, input logic [7:0] v, input logic [3:0] sel);
        logic [31:0] d;
        xfer(1'b1, idx, v, sel, d);
    endtask
    // Read and compare the whole word, upper bits zero
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        xfer(1'b0, idx, 8'h00, 4'hF, d);
        chk(d, {24'h0, exp});
    endtask
    // Let pins pass the synchroniser, then look at settled ports
    task automatic pc(input logic [5:0] got, input logic [5:0] exp);
        chk({26'h0, got}, {26'h0, exp});
    endtask
    task automatic wt();
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        // Reset values and unmapped place
        rd(IDX_DIR, 8'h3F);
        rd(IDX_PULLUP, 8'h37);
        rd(IDX_CHGEN, 8'h00);
        rd(IDX_OPTION, 8'hFF);
        rd(IDX_INTCTL, 8'h00);
        rd(8'h40, 8'h00);
        rd(IDX_DATA, 8'h28);
        wt();
        pc(padOe_n, 6'h3F);
        pc(pullUpOn, 6'h00);
        pc({4'h0, irqRequest, wakeRequest}, 6'h00);
        $display("test reset done");
        // Output drive, input-only pin, master clear, analog masking
        wr(IDX_ANALOG, 8'h00);
        wr(IDX_DATA, 8'h15);
        wr(IDX_DIR, 8'h00);
        rd(IDX_DIR, 8'h08);
        wrs(IDX_DIR, 8'h3F, 4'hE);
        rd(IDX_DIR, 8'h08);
        wt();
        pc(padOe_n, 6'h08);
        pc(padOut, 6'h15);
        rd(IDX_DATA, 8'h1D);
        mclr <= 1'b1;
        wt();
        rd(IDX_DATA, 8'h15);
        mclr <= 1'b0;
        wr(IDX_DATA, 8'hFF);
        wt();
        pc(padOut, 6'h37);
        rd(IDX_DATA, 8'h3F);
        wr(IDX_ANALOG, 8'h0F);
        wt();
        pc(padOe_n, 6'h08);
        rd(IDX_DATA, 8'h28);
        wr(IDX_DIR, 8'h3F);
        wr(IDX_ANALOG, 8'h00);
        $display("test drive done");
        // Pull-ups under global control and direction
        extEn <= 6'h00;
        wr(IDX_OPTION, 8'h7F);
        wt();
        pc(pullUpOn, 6'h37);
        wr(IDX_DIR, 8'h3E);
        wt();
        pc(pullUpOn, 6'h36);
        wr(IDX_PULLUP, 8'hFF);
        rd(IDX_PULLUP, 8'h37);
        wr(IDX_PULLUP, 8'h05);
        wt();
        pc(pullUpOn, 6'h04);
        wr(IDX_OPTION, 8'hFF);
        wt();
        pc(pullUpOn, 6'h00);
        extEn <= 6'h3F;
        wr(IDX_DIR, 8'h3F);
        $display("test pull-up done");
        // Peripheral ownership, input-only pin never driven
        own <= 6'h09;
        pOut <= 6'h09;
        pOe_n <= 6'h36;
        wt();
        pc(padOe_n, 6'h3E);
        pc({5'h00, padOut[0]}, 6'h01);
        own <= 6'h00;
        pOe_n <= 6'h3F;
        $display("test peripheral done");
        // Change detection, flag, masking and clearing
        wr(IDX_CHGEN, 8'hF7);
        rd(IDX_CHGEN, 8'h37);
        wt();
        rd(IDX_DATA, 8'h2A);
        wr(IDX_INTCTL, 8'h00);
        extVal <= 6'h22;
        wt();
        rd(IDX_INTCTL, 8'h00);
        extVal <= 6'h23;
        wt();
        rd(IDX_INTCTL, 8'h01);
        pc({4'h0, irqRequest, wakeRequest}, 6'h00);
        wr(IDX_INTCTL, 8'h08);
        wt();
        pc({4'h0, irqRequest, wakeRequest}, 6'h01);
        wr(IDX_INTCTL, 8'h88);
        rd(IDX_INTCTL, 8'h89);
        wt();
        pc({4'h0, irqRequest, wakeRequest}, 6'h03);
        rd(IDX_DATA, 8'h23);
        wr(IDX_INTCTL, 8'h88);
        rd(IDX_INTCTL, 8'h88);
        wt();
        pc({4'h0, irqRequest, wakeRequest}, 6'h00);
        extVal <= 6'h22;
        wt();
        rd(IDX_INTCTL, 8'h89);
        wr(IDX_DATA, 8'h00);
        wr(IDX_INTCTL, 8'h88);
        rd(IDX_INTCTL, 8'h88);
        $display("test change done");
        finish_test();
    end
endmodule
`default_nettype wire
